// ==== hdl/branch_pkg.sv ====
// shared types and constants for the conditional relative branch unit
package branch_pkg;

    // datapath widths
    localparam int PC_W = 16;
    localparam int K_W = 7;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // the constant one in program_counter + k + 1
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;

    // branch operations presented by the instruction decoder
    typedef enum logic [3:0] {
        OP_NOT_EQUAL = 4'h0,
        OP_CARRY_SET = 4'h1,
        OP_CARRY_CLEAR = 4'h2,
        OP_SAME_OR_HIGHER = 4'h3,
        OP_LOWER = 4'h4,
        OP_MINUS = 4'h5,
        OP_PLUS = 4'h6,
        OP_SIGNED_GE = 4'h7,
        OP_SIGNED_LT = 4'h8,
        OP_HALF_CARRY_SET = 4'h9,
        OP_HALF_CARRY_CLEAR = 4'hA,
        OP_TRANSFER_SET = 4'hB,
        OP_TRANSFER_CLEAR = 4'hC,
        OP_OVERFLOW_SET = 4'hD
    } branch_op_t;

    localparam int OP_COUNT = 16;

    // status flags as read from the status register
    typedef struct packed {
        logic half_carry;
        logic transfer;
        logic negative;
        logic overflow;
        logic zero;
        logic carry;
    } status_flags_t;

    // one branch request from the decoder
    typedef struct packed {
        logic valid;
        branch_op_t op;
        logic [K_W-1:0] offset;
        logic [PC_W-1:0] program_counter;
        status_flags_t flags;
    } branch_req_t;

    // branch result handed to the program counter
    typedef struct packed {
        logic taken;
        logic [PC_W-1:0] next_pc;
    } branch_res_t;

    // sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_REFILL = 2'b10
    } seq_state_t;

    // register map
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_TAKEN_COUNT = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_FALL_COUNT = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_LAST_TARGET = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h04;

    // control and state fields
    localparam int CTRL_COUNT_EN_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_TAKEN_BIT = 1;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0001;
    localparam logic [DATA_W-1:0] COUNT_STEP = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [PC_W-1:0] PC_ZERO = 16'h0000;

endpackage

// ==== hdl/branch_condition.sv ====
// evaluates the flag test of one branch operation
`timescale 1ns/1ps
`default_nettype none
module branch_condition (
    input wire branch_pkg::branch_op_t op,
    input wire branch_pkg::status_flags_t flags,
    output logic taken
);
    logic [branch_pkg::OP_COUNT-1:0] cond_vec;
    logic signed_less;

    // signed compare result from negative xor overflow
    assign signed_less = flags.negative ^ flags.overflow;

    // one condition per operation code
    assign cond_vec[branch_pkg::OP_NOT_EQUAL] = ~flags.zero;
    assign cond_vec[branch_pkg::OP_CARRY_SET] = flags.carry;
    assign cond_vec[branch_pkg::OP_LOWER] = flags.carry;
    assign cond_vec[branch_pkg::OP_CARRY_CLEAR] = ~flags.carry;
    assign cond_vec[branch_pkg::OP_SAME_OR_HIGHER] = ~flags.carry;
    assign cond_vec[branch_pkg::OP_MINUS] = flags.negative;
    assign cond_vec[branch_pkg::OP_PLUS] = ~flags.negative;
    assign cond_vec[branch_pkg::OP_SIGNED_GE] = ~signed_less;
    assign cond_vec[branch_pkg::OP_SIGNED_LT] = signed_less;
    assign cond_vec[branch_pkg::OP_HALF_CARRY_SET] = flags.half_carry;
    assign cond_vec[branch_pkg::OP_HALF_CARRY_CLEAR] = ~flags.half_carry;
    assign cond_vec[branch_pkg::OP_TRANSFER_SET] = flags.transfer;
    assign cond_vec[branch_pkg::OP_TRANSFER_CLEAR] = ~flags.transfer;
    assign cond_vec[branch_pkg::OP_OVERFLOW_SET] = flags.overflow;
    // undefined codes never branch
    assign cond_vec[branch_pkg::OP_COUNT-1:branch_pkg::OP_COUNT-2] = 2'h0;

    assign taken = cond_vec[op];

endmodule // branch_condition
`default_nettype wire

// ==== hdl/branch_target.sv ====
// forms the branch target and the fall-through address
`timescale 1ns/1ps
`default_nettype none
module branch_target (
    input wire logic [branch_pkg::PC_W-1:0] program_counter,
    input wire logic [branch_pkg::K_W-1:0] offset,
    output logic [branch_pkg::PC_W-1:0] target,
    output logic [branch_pkg::PC_W-1:0] fall_through
);
    logic [branch_pkg::PC_W-1:0] offset_ext;

    // sign-extend k, counted in instruction words
    assign offset_ext = {{(branch_pkg::PC_W-branch_pkg::K_W){offset[branch_pkg::K_W-1]}},
                         offset};
    // program_counter + k + 1, wrapping at the counter width
    assign target = program_counter + offset_ext + branch_pkg::PC_STEP;
    assign fall_through = program_counter + branch_pkg::PC_STEP;

endmodule // branch_target
`default_nettype wire

// ==== hdl/branch_unit.sv ====
// conditional relative branch unit with result sequencing and status registers
//
// Functional notes
// - not-equal branches when zero flag is 0
// - carry set and lower branch on carry 1
// - carry clear, same-or-higher branch on carry 0
// - minus branches when negative flag is 1
// - plus branches when negative flag is 0
// - signed ge branches when negative xor overflow 0
// - signed lt branches when negative xor overflow 1
// - half-carry set branches when half-carry is 1
// - half-carry clear branches when half-carry is 0
// - transfer set branches when transfer flag 1
// - transfer clear branches when transfer flag 0
// - overflow set branches when overflow flag 1
// - target is pc+k+1, flags untouched, 1/2 cycles
`timescale 1ns/1ps
`default_nettype none
module branch_unit (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    input wire branch_pkg::branch_req_t req,
    output logic req_ready,
    output logic res_valid_r,
    output branch_pkg::branch_res_t res_r,
    input wire logic [branch_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [branch_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [branch_pkg::DATA_W-1:0] reg_rdata_r
);
    branch_pkg::seq_state_t state_r;
    branch_pkg::seq_state_t state_nxt;
    logic cond_taken;
    logic accept;
    logic [branch_pkg::PC_W-1:0] target;
    logic [branch_pkg::PC_W-1:0] fall_through;
    branch_pkg::branch_res_t res_nxt;
    logic [branch_pkg::DATA_W-1:0] ctrl_r;
    logic [branch_pkg::DATA_W-1:0] taken_count_r;
    logic [branch_pkg::DATA_W-1:0] fall_count_r;
    logic [branch_pkg::PC_W-1:0] last_target_r;
    logic last_taken_r;
    logic count_en;
    logic count_clear;
    logic wr_ctrl;
    logic [branch_pkg::DATA_W-1:0] rd_mux;
    logic [branch_pkg::DATA_W-1:0] state_word;

    // flag test and address arithmetic
    branch_condition u_cond (
        .op(req.op),
        .flags(req.flags),
        .taken(cond_taken)
    );

    branch_target u_target (
        .program_counter(req.program_counter),
        .offset(req.offset),
        .target(target),
        .fall_through(fall_through)
    );

    // handshake: a taken branch holds off the next request one cycle
    assign req_ready = (state_r == branch_pkg::ST_IDLE);
    assign accept = req.valid && req_ready;

    // result selection; the flags are only read, never written back
    assign res_nxt.taken = cond_taken;
    assign res_nxt.next_pc = cond_taken ? target : fall_through;

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            branch_pkg::ST_IDLE: begin
                if (accept && cond_taken) begin
                    state_nxt = branch_pkg::ST_REFILL;
                end
            end
            branch_pkg::ST_REFILL: begin
                state_nxt = branch_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = branch_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer and result registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= branch_pkg::ST_IDLE;
            res_valid_r <= 1'b0;
            res_r <= '0;
        end else if (clock_en) begin
            state_r <= state_nxt;
            res_valid_r <= accept;
            if (accept) begin
                res_r <= res_nxt;
            end
        end
    end

    // register decode
    assign wr_ctrl = reg_write && (reg_addr == branch_pkg::ADDR_CTRL);
    assign count_en = ctrl_r[branch_pkg::CTRL_COUNT_EN_BIT];
    assign count_clear = wr_ctrl && reg_wdata[branch_pkg::CTRL_CLEAR_BIT];
    assign state_word = {{(branch_pkg::DATA_W-2){1'b0}}, last_taken_r,
                         (state_r == branch_pkg::ST_REFILL)};
    assign rd_mux = (reg_addr == branch_pkg::ADDR_CTRL) ? ctrl_r :
                    (reg_addr == branch_pkg::ADDR_TAKEN_COUNT) ? taken_count_r :
                    (reg_addr == branch_pkg::ADDR_FALL_COUNT) ? fall_count_r :
                    (reg_addr == branch_pkg::ADDR_LAST_TARGET) ? last_target_r :
                    (reg_addr == branch_pkg::ADDR_STATE) ? state_word :
                    branch_pkg::DATA_ZERO;

    // control register; the clear bit acts on write and is not stored
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_r <= branch_pkg::CTRL_RESET;
        end else if (clock_en && wr_ctrl) begin
            ctrl_r <= reg_wdata & branch_pkg::CTRL_RESET;
        end
    end

    // branch statistics; a clear in the same cycle as an event loses to it
    always_ff @(posedge clock) begin
        if (reset) begin
            taken_count_r <= branch_pkg::DATA_ZERO;
            fall_count_r <= branch_pkg::DATA_ZERO;
        end else if (clock_en) begin
            if (count_clear) begin
                taken_count_r <= branch_pkg::DATA_ZERO;
                fall_count_r <= branch_pkg::DATA_ZERO;
            end
            if (accept && count_en && cond_taken) begin
                taken_count_r <= count_clear ? branch_pkg::COUNT_STEP
                                             : taken_count_r + branch_pkg::COUNT_STEP;
            end
            if (accept && count_en && !cond_taken) begin
                fall_count_r <= count_clear ? branch_pkg::COUNT_STEP
                                            : fall_count_r + branch_pkg::COUNT_STEP;
            end
        end
    end

    // last outcome seen by software
    always_ff @(posedge clock) begin
        if (reset) begin
            last_target_r <= branch_pkg::PC_ZERO;
            last_taken_r <= 1'b0;
        end else if (clock_en && accept) begin
            last_target_r <= res_nxt.next_pc;
            last_taken_r <= cond_taken;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata_r <= branch_pkg::DATA_ZERO;
        end else if (clock_en) begin
            reg_rdata_r <= reg_read ? rd_mux : branch_pkg::DATA_ZERO;
        end
    end

    // condition checks on the registered result
    ne_cond_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_NOT_EQUAL)
        |=> (res_r.taken == !$past(req.flags.zero)))
        else $error("not-equal outcome wrong");
    carry_set_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && (req.op == branch_pkg::OP_CARRY_SET
                                || req.op == branch_pkg::OP_LOWER))
        |=> (res_r.taken == $past(req.flags.carry)))
        else $error("carry-set or lower outcome wrong");
    carry_clear_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && (req.op == branch_pkg::OP_CARRY_CLEAR
                                || req.op == branch_pkg::OP_SAME_OR_HIGHER))
        |=> (res_r.taken == !$past(req.flags.carry)))
        else $error("carry-clear or same-or-higher outcome wrong");
    minus_cond_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_MINUS)
        |=> (res_r.taken == $past(req.flags.negative)))
        else $error("minus outcome wrong");
    plus_cond_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_PLUS)
        |=> (res_r.taken == !$past(req.flags.negative)))
        else $error("plus outcome wrong");
    signed_ge_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_SIGNED_GE)
        |=> (res_r.taken == ($past(req.flags.negative) == $past(req.flags.overflow))))
        else $error("signed ge outcome wrong");
    signed_lt_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_SIGNED_LT)
        |=> (res_r.taken == ($past(req.flags.negative) != $past(req.flags.overflow))))
        else $error("signed lt outcome wrong");
    half_set_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_HALF_CARRY_SET)
        |=> (res_r.taken == $past(req.flags.half_carry)))
        else $error("half-carry set outcome wrong");
    half_clear_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_HALF_CARRY_CLEAR)
        |=> (res_r.taken == !$past(req.flags.half_carry)))
        else $error("half-carry clear outcome wrong");
    transfer_set_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_TRANSFER_SET)
        |=> (res_r.taken == $past(req.flags.transfer)))
        else $error("transfer set outcome wrong");
    transfer_clear_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_TRANSFER_CLEAR)
        |=> (res_r.taken == !$past(req.flags.transfer)))
        else $error("transfer clear outcome wrong");
    overflow_set_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && req.op == branch_pkg::OP_OVERFLOW_SET)
        |=> (res_r.taken == $past(req.flags.overflow)))
        else $error("overflow set outcome wrong");

    // address and timing checks
    target_addr_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && cond_taken)
        |=> (res_valid_r && res_r.next_pc == $past(req.program_counter)
             + {{(branch_pkg::PC_W-branch_pkg::K_W){$past(req.offset[branch_pkg::K_W-1])}},
                $past(req.offset)} + branch_pkg::PC_STEP))
        else $error("branch target not pc+k+1");
    taken_two_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && cond_taken) ##1 clock_en
        |-> !req_ready ##1 req_ready)
        else $error("taken branch not two cycles");
    fall_one_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && !cond_taken)
        |=> (req_ready && res_r.next_pc == $past(req.program_counter) + branch_pkg::PC_STEP))
        else $error("fall-through not one cycle");

    // result pulse, hold, refusal and last-outcome checks
    res_pulse_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && !accept)
        |=> !res_valid_r)
        else $error("result valid longer than one cycle");
    res_hold_a: assert property (@(posedge clock) disable iff (reset)
        !(clock_en && accept)
        |=> $stable(res_r))
        else $error("result changed without a request");
    refill_refuse_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && req.valid && !req_ready)
        |=> !res_valid_r)
        else $error("request taken during refill");
    last_outcome_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept)
        |=> (last_taken_r == res_r.taken && last_target_r == res_r.next_pc))
        else $error("last outcome differs from result");

    // register port read data and control clear-bit checks
    rdata_idle_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && !reg_read)
        |=> (reg_rdata_r == branch_pkg::DATA_ZERO))
        else $error("read data not zero outside a read");
    rdata_count_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && reg_read && reg_addr == branch_pkg::ADDR_TAKEN_COUNT)
        |=> (reg_rdata_r == $past(taken_count_r)))
        else $error("taken count read back wrong");
    busy_bit_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && reg_read && reg_addr == branch_pkg::ADDR_STATE)
        |=> (reg_rdata_r[branch_pkg::STATE_BUSY_BIT] == !$past(req_ready)))
        else $error("busy bit does not show the refill cycle");
    unmapped_read_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && reg_read && reg_addr > branch_pkg::ADDR_STATE)
        |=> (reg_rdata_r == branch_pkg::DATA_ZERO))
        else $error("unmapped read not zero");
    ctrl_clear_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && wr_ctrl)
        |=> !ctrl_r[branch_pkg::CTRL_CLEAR_BIT])
        else $error("clear bit stored in control");

    // branch statistics checks; an event beside a clear wins
    taken_count_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && count_en && cond_taken && !count_clear)
        |=> (taken_count_r == $past(taken_count_r) + branch_pkg::COUNT_STEP))
        else $error("taken count did not step");
    fall_count_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && count_en && !cond_taken && !count_clear)
        |=> (fall_count_r == $past(fall_count_r) + branch_pkg::COUNT_STEP))
        else $error("not-taken count did not step");
    set_wins_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && accept && count_en && count_clear)
        |=> (taken_count_r + fall_count_r == branch_pkg::COUNT_STEP))
        else $error("event beside a clear lost");
    clear_wins_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && count_clear && !(accept && count_en))
        |=> (taken_count_r == branch_pkg::DATA_ZERO
             && fall_count_r == branch_pkg::DATA_ZERO))
        else $error("counters not cleared");
    count_hold_a: assert property (@(posedge clock) disable iff (reset)
        (clock_en && !count_en && !count_clear)
        |=> ($stable(taken_count_r) && $stable(fall_count_r)))
        else $error("counters moved while counting is off");

    // reset state and clock-enable freeze
    reset_state_a: assert property (@(posedge clock)
        reset
        |=> (req_ready && !res_valid_r && ctrl_r == branch_pkg::CTRL_RESET
             && reg_rdata_r == branch_pkg::DATA_ZERO))
        else $error("reset state wrong");
    freeze_hold_a: assert property (@(posedge clock) disable iff (reset)
        !clock_en
        |=> ($stable(state_r) && $stable(res_valid_r) && $stable(taken_count_r)
             && $stable(reg_rdata_r)))
        else $error("state moved while clock enable low");

endmodule // branch_unit
`default_nettype wire

// ==== testbench/tb_branch_unit.sv ====
// self-checking testbench for the conditional relative branch unit
`timescale 1ns/1ps
`default_nettype none
module tb_branch_unit;
    logic clock;
    logic reset;
    logic clock_en;
    branch_pkg::branch_req_t req;
    logic req_ready;
    logic res_valid_r;
    branch_pkg::branch_res_t res_r;
    logic [branch_pkg::ADDR_W-1:0] reg_addr;
    logic [branch_pkg::DATA_W-1:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [branch_pkg::DATA_W-1:0] reg_rdata_r;
    int failures;
    int cmp_count;
    logic [15:0] n_taken;
    logic [15:0] n_fall;
    logic [15:0] last_pc;
    logic last_t;
    logic count_en;

    branch_unit dut (
        .clock(clock), .reset(reset), .clock_en(clock_en), .req(req), .req_ready(req_ready),
        .res_valid_r(res_valid_r), .res_r(res_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_r(reg_rdata_r)
    );

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // compares one value and counts the outcome
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // prints the counts and the verdict, then ends the run
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // expected outcome of the flag test; f holds h,t,n,v,z,c from msb down
    function automatic logic cond(input logic [3:0] op, input logic [5:0] f);
        case (op)
            4'h0: cond = !f[1];
            4'h1, 4'h4: cond = f[0];
            4'h2, 4'h3: cond = !f[0];
            4'h5: cond = f[3];
            4'h6: cond = !f[3];
            4'h7: cond = !(f[3] ^ f[2]);
            4'h8: cond = f[3] ^ f[2];
            4'h9: cond = f[5];
            4'hA: cond = !f[5];
            4'hB: cond = f[4];
            4'hC: cond = !f[4];
            4'hD: cond = f[2];
            default: cond = 1'b0;
        endcase
    endfunction

    // one branch request, checked against the expected result
    task automatic branch(input logic [3:0] op, input logic [5:0] f, input logic [6:0] k,
                          input logic [15:0] pc);
        logic t;
        logic [15:0] exp_pc;
        t = cond(op, f);
        exp_pc = t ? pc + {{9{k[6]}}, k} + 16'h0001 : pc + 16'h0001;
        req.valid <= 1'b1;
        req.op <= branch_pkg::branch_op_t'(op);
        req.offset <= k;
        req.program_counter <= pc;
        req.flags <= branch_pkg::status_flags_t'(f);
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        check("res_valid", {15'h0000, res_valid_r}, 16'h0001);
        check("taken", {15'h0000, res_r.taken}, {15'h0000, t});
        check("next_pc", res_r.next_pc, exp_pc);
        check("req_ready", {15'h0000, req_ready}, {15'h0000, !t});
        if (count_en) begin
            if (t) n_taken++;
            else n_fall++;
        end
        last_pc = exp_pc;
        last_t = t;
        if (t) begin
            @(posedge clock);
            #1;
            check("ready_after_refill", {15'h0000, req_ready}, 16'h0001);
            check("valid_pulse", {15'h0000, res_valid_r}, 16'h0000);
        end
    endtask

    // register write, one cycle
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask

    // register read, data in the following cycle
    task automatic reg_rd(input string name, input logic [7:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(name, reg_rdata_r, exp);
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        report_and_stop();
    end

    // main sequence
    initial begin
        failures = 0;
        cmp_count = 0;
        n_taken = 16'h0000;
        n_fall = 16'h0000;
        count_en = 1'b1;
        reset = 1'b1;
        clock_en = 1'b1;
        req = '0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        #1;
        check("ready_reset", {15'h0000, req_ready}, 16'h0001);
        check("valid_reset", {15'h0000, res_valid_r}, 16'h0000);
        reg_rd("ctrl", branch_pkg::ADDR_CTRL, branch_pkg::CTRL_RESET);
        reg_rd("taken_cnt", branch_pkg::ADDR_TAKEN_COUNT, 16'h0000);
        reg_rd("last_target", branch_pkg::ADDR_LAST_TARGET, 16'h0000);
        reg_rd("unmapped", 8'h10, 16'h0000);
        // every op against every flag pattern, offsets of both signs
        for (int o = 0; o < 16; o++) begin
            for (int f = 0; f < 64; f++) begin
                branch(o[3:0], f[5:0], {f[5:0], o[0]}, {f[5:0], o[3:0], f[5:0]});
            end
        end
        // wrap at both ends of the address space, extreme offsets
        branch(4'h0, 6'h00, 7'h01, 16'hFFFF);
        branch(4'h1, 6'h01, 7'h40, 16'h0000);
        branch(4'hD, 6'h04, 7'h3F, 16'hFFC0);
        reg_rd("taken_cnt", branch_pkg::ADDR_TAKEN_COUNT, n_taken);
        reg_rd("fall_cnt", branch_pkg::ADDR_FALL_COUNT, n_fall);
        reg_rd("last_target", branch_pkg::ADDR_LAST_TARGET, last_pc);
        reg_rd("state", branch_pkg::ADDR_STATE, {14'h0000, last_t, 1'b0});
        // counting off, then clear and on again
        reg_wr(branch_pkg::ADDR_CTRL, 16'h0000);
        count_en = 1'b0;
        branch(4'h6, 6'h00, 7'h05, 16'h1234);
        reg_rd("taken_hold", branch_pkg::ADDR_TAKEN_COUNT, n_taken);
        reg_wr(branch_pkg::ADDR_CTRL, 16'h0003);
        reg_rd("taken_clr", branch_pkg::ADDR_TAKEN_COUNT, 16'h0000);
        reg_rd("fall_clr", branch_pkg::ADDR_FALL_COUNT, 16'h0000);
        reg_rd("ctrl_back", branch_pkg::ADDR_CTRL, branch_pkg::CTRL_RESET);
        // request held through the refill cycle is refused; busy reads back
        @(posedge clock);
        req.valid <= 1'b1;
        req.op <= branch_pkg::OP_PLUS;
        req.flags <= branch_pkg::status_flags_t'(6'h00);
        req.program_counter <= 16'h0100;
        req.offset <= 7'h10;
        @(posedge clock);
        reg_addr <= branch_pkg::ADDR_STATE;
        reg_read <= 1'b1;
        @(posedge clock);
        req.valid <= 1'b0;
        reg_read <= 1'b0;
        #1;
        check("refused_valid", {15'h0000, res_valid_r}, 16'h0000);
        check("state_busy", reg_rdata_r, 16'h0003);
        check("held_pc", res_r.next_pc, 16'h0111);
        @(posedge clock);
        #1;
        check("rdata_idle", reg_rdata_r, 16'h0000);
        check("ready_back", {15'h0000, req_ready}, 16'h0001);
        // clear and a counted not-taken branch in one cycle: the event wins
        req.valid <= 1'b1;
        req.flags <= branch_pkg::status_flags_t'(6'h08);
        reg_addr <= branch_pkg::ADDR_CTRL;
        reg_wdata <= 16'h0003;
        reg_write <= 1'b1;
        @(posedge clock);
        req.valid <= 1'b0;
        reg_write <= 1'b0;
        #1;
        check("clear_taken", {15'h0000, res_r.taken}, 16'h0000);
        reg_rd("fall_set_wins", branch_pkg::ADDR_FALL_COUNT, 16'h0001);
        reg_rd("taken_cleared", branch_pkg::ADDR_TAKEN_COUNT, 16'h0000);
        // a frozen clock enable holds off the accept
        @(posedge clock);
        clock_en <= 1'b0;
        req.valid <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check("frozen_valid", {15'h0000, res_valid_r}, 16'h0000);
        clock_en <= 1'b1;
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        check("thawed_valid", {15'h0000, res_valid_r}, 16'h0001);
        repeat (2) @(posedge clock);
        report_and_stop();
    end
endmodule // tb_branch_unit
`default_nettype wire
